//--- pkg/codec_link_if.sv
// Packet link between the sending end and the correlator / despreader
`timescale 1ns/1ps
interface codec_link_if;
	import codec_pkg::*;
	logic                  in_valid;
	logic                  in_ready;
	logic [WORD_W-1:0]     in_data;
	logic                  in_last;
	mode_type              mode;
	logic [ANT_W-1:0]      ant_count;
	logic [INFO_W-1:0]     info_bits;
	logic                  reduced;
	logic                  cplx;
	logic [CHAN_W-1:0]     num_chan;
	ratio_arr_type         spread_ratio;
	len_arr_type           chan_len;
	logic                  out_valid;
	logic                  out_ready;
	logic [WORD_W-1:0]     out_data;
	logic                  out_last;
	modport dev (input in_valid, in_data, in_last, mode, ant_count, info_bits, reduced, cplx,
		num_chan, spread_ratio, chan_len, out_ready,
		output in_ready, out_valid, out_data, out_last);
	modport host (output in_valid, in_data, in_last, mode, ant_count, info_bits, reduced, cplx,
		num_chan, spread_ratio, chan_len, out_ready,
		input in_ready, out_valid, out_data, out_last);
endinterface

//--- pkg/codec_pkg.sv
// Shared constants and types for the uplink correlator / despreader link
package codec_pkg;
	localparam int WORD_W        = 128;
	localparam int LANE_W        = 16;
	localparam int COMP_W        = 8;
	localparam int LANES         = 8;
	localparam int CPLX_LANES    = 4;
	localparam int CPLX_W        = 32;
	localparam int MAX_ANT       = 8;
	localparam int ANT_W         = 4;
	localparam int WORDS_PER_ANT = 2;
	localparam int MAX_INFO_BITS = 13;
	localparam int INFO_W        = 4;
	localparam int DATA_SYMS     = 10;
	localparam int HALF_SYMS     = 5;
	localparam int PILOTS        = 4;
	localparam int CODED_BITS    = 20;
	localparam int PILOT_LANE    = 4;
	localparam int RES_LANE      = 2;
	localparam int EXT_CP_LANE_A = 5;
	localparam int EXT_CP_LANE_B = 7;
	localparam int CORR_W        = 25;
	localparam int MEAN_W        = 32;
	localparam int FIELD_W       = 32;
	localparam int OUT_CORR_LSB  = 64;
	localparam int OUT_MEAN_LSB  = 64;
	localparam int BEST_N        = 4;
	localparam int RED_SKIP_BIT  = 5;
	localparam int RED_DROP      = 2;
	localparam int RED_MIN_BITS  = 6;
	localparam int MAX_CHAN      = 6;
	localparam int CHAN_W        = 3;
	localparam int RATIO_W       = 8;
	localparam int LEN_W         = 16;
	// Control value software sets for correlation use; no register here
	localparam logic [7:0] CTRL_SETTING = 8'h1b;
	// Default codeword table, one column per information bit, row 0 in bit 0
	localparam logic [CODED_BITS-1:0] CW_TABLE [MAX_INFO_BITS] = '{
		20'hfffff, 20'h5a933, 20'h10e5a, 20'h6339c, 20'h7c3e0, 20'hffc00, 20'hd8e64,
		20'h4f5b0, 20'h218ec, 20'h1b746, 20'h0ffff, 20'h33fff, 20'h3fffc};
	typedef enum logic {MODE_CORR, MODE_DESPREAD} mode_type;
	typedef logic [MAX_CHAN-1:0][RATIO_W-1:0] ratio_arr_type;
	typedef logic [MAX_CHAN-1:0][LEN_W-1:0]   len_arr_type;
endpackage

//--- rtl/codec_device.sv
// Correlator and final despreader end of the packet link
`timescale 1ns/1ps
module codec_device
	import codec_pkg::*;
#(
	parameter int ACC_W = 24
) (
	input  wire logic  sys_clk,
	input  wire logic  rst,
	output logic       busy,
	codec_link_if.dev  link
);
	localparam int SUM_W = 14;
	localparam int MAG_W = 28;
	localparam int SUM_ACC_W = 48;

	if (ACC_W < LANE_W || ACC_W > FIELD_W) begin : g_bad_acc
		$error("ACC_W must lie between 16 and 32");
	end

	typedef enum logic [3:0] {ST_IDLE, ST_CLOAD, ST_CRUN, ST_CINS0, ST_CINS1,
		ST_COUT0, ST_COUT1, ST_DRUN, ST_DFLUSH} state_type;
	state_type                  state_q, state_d;
	mode_type                   mode_q, mode_d;
	logic [ANT_W-1:0]           ant_q, ant_d;
	logic [INFO_W-1:0]          bits_q, bits_d;
	logic                       red_q, red_d, cplx_q, cplx_d;
	logic [CHAN_W-1:0]          nch_q, nch_d, ch_q, ch_d;
	ratio_arr_type              ratio_q, ratio_d;
	len_arr_type                len_q, len_d;
	logic [WORD_W-1:0]          samp_q [MAX_ANT*WORDS_PER_ANT];
	logic [WORD_W-1:0]          samp_d [MAX_ANT*WORDS_PER_ANT];
	logic [ANT_W-1:0]           wcnt_q, wcnt_d;
	logic [MAX_INFO_BITS-1:0]   cand_q, cand_d, cand_bits, last_cand, ins_i;
	logic [ANT_W-2:0]           aidx_q, aidx_d;
	logic [MAG_W-1:0]           acc0_q, acc0_d, acc1_q, acc1_d, mag0, mag1;
	logic [CORR_W-1:0]          bc_q [BEST_N], bc_d [BEST_N], ins_c [BEST_N], ins_v;
	logic [MAX_INFO_BITS-1:0]   bi_q [BEST_N], bi_d [BEST_N], ins_x [BEST_N];
	logic [BEST_N-1:0]          gt;
	logic [SUM_ACC_W-1:0]       sum_q, sum_d;
	logic [WORD_W-1:0]          word_q, word_d, ob_q, ob_d, ob_n, w0, w1;
	logic                       have_q, have_d, ov_q, ov_d, ol_q, ol_d, out_free, red_eff;
	logic [WORD_W-1:0]          od_q, od_d;
	logic [2:0]                 lane_q, lane_d;
	logic [3:0]                 olane_q, olane_d, pos;
	logic [LEN_W-1:0]           sym_q, sym_d;
	logic [RATIO_W-1:0]         grp_q, grp_d;
	logic signed [ACC_W-1:0]    acci_q, acci_d, accq_q, accq_d, acci_n, accq_n;
	logic [CODED_BITS-1:0]      coded;
	logic [2*WORD_W-1:0]        aw;
	logic signed [SUM_W-1:0]    yi, yq, tre, tim, re1, im1, re2, im2, sr0, si0, sr1, si1;
	logic                       g, ce, ovf;
	logic [CPLX_W-1:0]          packed_sym;

	function automatic logic signed [SUM_W-1:0] comp(input logic [COMP_W-1:0] v);
		return SUM_W'($signed(v));
	endfunction

	function automatic logic [LANE_W-1:0] sat16(input logic signed [ACC_W-1:0] v);
		logic signed [ACC_W-1:0] hi;
		logic signed [ACC_W-1:0] lo;
		hi = ACC_W'(16'sh7fff);
		lo = ACC_W'(-17'sh08000);
		if (v > hi) return 16'h7fff;
		if (v < lo) return 16'h8000;
		return v[LANE_W-1:0];
	endfunction

	function automatic logic [CORR_W-1:0] sat_corr(input logic [MAG_W-1:0] v);
		return (|v[MAG_W-1:CORR_W]) ? '1 : v[CORR_W-1:0];
	endfunction

	// ****************************************
	// Correlation datapath for one antenna
	// ****************************************
	always_comb begin
		red_eff   = red_q && (bits_q >= INFO_W'(RED_MIN_BITS));
		// Reduced search holds bit 0 at zero and keeps bit 5 for the half split
		cand_bits = red_eff ? MAX_INFO_BITS'({cand_q[MAX_INFO_BITS-1:RED_SKIP_BIT-1], 1'b0,
			cand_q[RED_SKIP_BIT-2:0], 1'b0}) : cand_q;
		last_cand = MAX_INFO_BITS'((red_eff ? (32'd1 << (bits_q - INFO_W'(RED_DROP)))
			: (32'd1 << bits_q)) - 32'd1);
		for (int i = 0; i < CODED_BITS; i++) begin
			coded[i] = 1'b0;
			for (int k = 0; k < MAX_INFO_BITS; k++) begin
				coded[i] = coded[i] ^ (cand_bits[k] & CW_TABLE[k][i]);
			end
		end
		aw  = {samp_q[2*aidx_q+1], samp_q[2*aidx_q]};
		re1 = '0;
		im1 = '0;
		re2 = '0;
		im2 = '0;
		yi  = '0;
		yq  = '0;
		tre = '0;
		tim = '0;
		for (int j = 0; j < PILOTS; j++) begin
			re1 = re1 + comp(aw[WORD_W + (PILOT_LANE + j)*LANE_W +: COMP_W]);
			im1 = im1 + comp(aw[WORD_W + (PILOT_LANE + j)*LANE_W + COMP_W +: COMP_W]);
		end
		// Data symbols sit in the ten lowest lanes of the antenna's word pair
		for (int j = 0; j < DATA_SYMS; j++) begin
			yi  = comp(aw[j*LANE_W +: COMP_W]);
			yq  = comp(aw[j*LANE_W + COMP_W +: COMP_W]);
			tre = (coded[2*j] ? -yi : yi) + (coded[2*j+1] ? -yq : yq);
			tim = (coded[2*j] ? -yq : yq) - (coded[2*j+1] ? -yi : yi);
			if (j < HALF_SYMS) begin
				re1 = re1 + tre;
				im1 = im1 + tim;
			end else begin
				re2 = re2 + tre;
				im2 = im2 + tim;
			end
		end
		sr0  = re1 + re2;
		si0  = im1 + im2;
		sr1  = re1 - re2;
		si1  = im1 - im2;
		mag0 = MAG_W'(MAG_W'(sr0) * MAG_W'(sr0)) + MAG_W'(MAG_W'(si0) * MAG_W'(si0));
		mag1 = MAG_W'(MAG_W'(sr1) * MAG_W'(sr1)) + MAG_W'(MAG_W'(si1) * MAG_W'(si1));
		// Ranking: the list stays sorted, a tie keeps the earlier candidate
		ins_v = sat_corr(state_q == ST_CINS1 ? acc1_q : acc0_q);
		ins_i = cand_bits;
		if (state_q == ST_CINS1) begin
			ins_i[RED_SKIP_BIT] = 1'b1;
		end
		for (int k = 0; k < BEST_N; k++) begin
			gt[k] = ins_v > bc_q[k];
		end
		ins_c[0] = gt[0] ? ins_v : bc_q[0];
		ins_x[0] = gt[0] ? ins_i : bi_q[0];
		for (int k = 1; k < BEST_N; k++) begin
			ins_c[k] = gt[k] ? (gt[k-1] ? bc_q[k-1] : ins_v) : bc_q[k];
			ins_x[k] = gt[k] ? (gt[k-1] ? bi_q[k-1] : ins_i) : bi_q[k];
		end
		w0 = '0;
		w1 = '0;
		for (int k = 0; k < BEST_N; k++) begin
			w0[k*LANE_W +: MAX_INFO_BITS] = bi_q[k];
		end
		w0[OUT_CORR_LSB +: CORR_W]           = bc_q[0];
		w0[OUT_CORR_LSB + FIELD_W +: CORR_W] = bc_q[1];
		w1[0 +: CORR_W]                      = bc_q[2];
		w1[FIELD_W +: CORR_W]                = bc_q[3];
		w1[OUT_MEAN_LSB +: MEAN_W] = MEAN_W'(sum_q >> (red_eff ? bits_q - INFO_W'(1) : bits_q));
	end

	// ****************************************
	// Despreading datapath for one symbol
	// ****************************************
	always_comb begin
		acci_n = (grp_q == '0) ? '0 : acci_q;
		accq_n = (grp_q == '0) ? '0 : accq_q;
		// I and Q run in separate adders, so lane order inside a symbol is free
		if (cplx_q) begin
			acci_n = acci_n + ACC_W'($signed(word_q[lane_q*CPLX_W +: LANE_W]));
			accq_n = accq_n + ACC_W'($signed(word_q[lane_q*CPLX_W + LANE_W +: LANE_W]));
		end else begin
			acci_n = acci_n + ACC_W'($signed(word_q[lane_q*LANE_W +: LANE_W]));
		end
		g          = grp_q == ratio_q[ch_q] - RATIO_W'(1);
		ce         = sym_q == len_q[ch_q] - LEN_W'(1);
		ovf        = olane_q == (cplx_q ? 4'(CPLX_LANES) : 4'(LANES));
		pos        = ovf ? '0 : olane_q;
		packed_sym = cplx_q ? {sat16(accq_n), sat16(acci_n)} : {16'h0000, sat16(acci_n)};
		ob_n       = ovf ? '0 : ob_q;
		if (cplx_q) begin
			ob_n[pos*CPLX_W +: CPLX_W] = packed_sym;
		end else begin
			ob_n[pos*LANE_W +: LANE_W] = packed_sym[LANE_W-1:0];
		end
	end

	// ****************************************
	// Sequencing
	// ****************************************
	always_comb begin
		state_d = state_q;
		mode_d  = mode_q;
		ant_d   = ant_q;
		bits_d  = bits_q;
		red_d   = red_q;
		cplx_d  = cplx_q;
		nch_d   = nch_q;
		ratio_d = ratio_q;
		len_d   = len_q;
		samp_d  = samp_q;
		wcnt_d  = wcnt_q;
		cand_d  = cand_q;
		aidx_d  = aidx_q;
		acc0_d  = acc0_q;
		acc1_d  = acc1_q;
		bc_d    = bc_q;
		bi_d    = bi_q;
		sum_d   = sum_q;
		word_d  = word_q;
		have_d  = have_q;
		lane_d  = lane_q;
		ch_d    = ch_q;
		sym_d   = sym_q;
		grp_d   = grp_q;
		acci_d  = acci_q;
		accq_d  = accq_q;
		ob_d    = ob_q;
		olane_d = olane_q;
		out_free = !ov_q || link.out_ready;
		ov_d    = ov_q && !link.out_ready;
		od_d    = od_q;
		ol_d    = ol_q;
		link.in_ready = 1'b0;
		case (state_q)
			ST_IDLE: begin
				// Settings are caught once, when a packet first shows
				if (link.in_valid) begin
					mode_d  = link.mode;
					ant_d   = link.ant_count;
					bits_d  = link.info_bits;
					red_d   = link.reduced;
					cplx_d  = link.cplx;
					nch_d   = link.num_chan;
					ratio_d = link.spread_ratio;
					len_d   = link.chan_len;
					wcnt_d  = '0;
					cand_d  = '0;
					aidx_d  = '0;
					sum_d   = '0;
					bc_d    = '{default: '0};
					bi_d    = '{default: '0};
					ch_d    = '0;
					have_d  = 1'b0;
					lane_d  = '0;
					sym_d   = '0;
					grp_d   = '0;
					ob_d    = '0;
					olane_d = '0;
					state_d = (link.mode == MODE_CORR) ? ST_CLOAD : ST_DRUN;
				end
			end
			ST_CLOAD: begin
				link.in_ready = 1'b1;
				if (link.in_valid) begin
					samp_d[wcnt_d] = link.in_data;
					wcnt_d = wcnt_q + ANT_W'(1);
					if (wcnt_q == ANT_W'((5'(ant_q) << 1) - 5'd1)) begin
						state_d = ST_CRUN;
					end
				end
			end
			ST_CRUN: begin
				acc0_d = ((aidx_q == '0) ? '0 : acc0_q) + mag0;
				acc1_d = ((aidx_q == '0) ? '0 : acc1_q) + mag1;
				aidx_d = aidx_q + 3'd1;
				if (aidx_q == 3'(ant_q - ANT_W'(1))) begin
					aidx_d  = '0;
					state_d = ST_CINS0;
				end
			end
			ST_CINS0, ST_CINS1: begin
				bc_d  = ins_c;
				bi_d  = ins_x;
				sum_d = sum_q + SUM_ACC_W'(ins_v);
				if (red_eff && state_q == ST_CINS0) begin
					state_d = ST_CINS1;
				end else if (cand_q == last_cand) begin
					state_d = ST_COUT0;
				end else begin
					cand_d  = cand_q + MAX_INFO_BITS'(1);
					state_d = ST_CRUN;
				end
			end
			ST_COUT0, ST_COUT1: begin
				if (out_free) begin
					ov_d    = 1'b1;
					od_d    = (state_q == ST_COUT0) ? w0 : w1;
					ol_d    = state_q == ST_COUT1;
					state_d = (state_q == ST_COUT0) ? ST_COUT1 : ST_IDLE;
				end
			end
			ST_DRUN: begin
				link.in_ready = !have_q;
				if (!have_q) begin
					if (link.in_valid) begin
						word_d = link.in_data;
						have_d = 1'b1;
						lane_d = '0;
					end
				end else if (!(g && ovf && !out_free)) begin
					// A full output word leaves when the next symbol needs room, or in ST_DFLUSH at channel end
					if (g && ovf) begin
						ov_d = 1'b1;
						od_d = ob_q;
						ol_d = 1'b0;
					end
					if (g) begin
						ob_d    = ob_n;
						olane_d = pos + 4'd1;
					end
					acci_d = acci_n;
					accq_d = accq_n;
					grp_d  = g ? '0 : grp_q + RATIO_W'(1);
					sym_d  = sym_q + LEN_W'(1);
					lane_d = lane_q + 3'd1;
					if (lane_q == (cplx_q ? 3'(CPLX_LANES - 1) : 3'(LANES - 1))) begin
						have_d = 1'b0;
					end
					// Rest of the word after a channel's last symbol is pad
					if (ce) begin
						have_d  = 1'b0;
						sym_d   = '0;
						grp_d   = '0;
						state_d = ST_DFLUSH;
					end
				end
			end
			ST_DFLUSH: begin
				if (olane_q == '0 || out_free) begin
					if (olane_q != '0) begin
						ov_d = 1'b1;
						od_d = ob_q;
						ol_d = ch_q == nch_q - CHAN_W'(1);
					end
					ob_d    = '0;
					olane_d = '0;
					ch_d    = ch_q + CHAN_W'(1);
					state_d = (ch_q == nch_q - CHAN_W'(1)) ? ST_IDLE : ST_DRUN;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	assign busy          = state_q != ST_IDLE;
	assign link.out_valid = ov_q;
	assign link.out_data  = od_q;
	assign link.out_last  = ol_q;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_q <= ST_IDLE;
			mode_q  <= MODE_CORR;
			ant_q   <= '0;
			bits_q  <= '0;
			red_q   <= 1'b0;
			cplx_q  <= 1'b0;
			nch_q   <= '0;
			ratio_q <= '0;
			len_q   <= '0;
			samp_q  <= '{default: '0};
			wcnt_q  <= '0;
			cand_q  <= '0;
			aidx_q  <= '0;
			acc0_q  <= '0;
			acc1_q  <= '0;
			bc_q    <= '{default: '0};
			bi_q    <= '{default: '0};
			sum_q   <= '0;
			word_q  <= '0;
			have_q  <= 1'b0;
			lane_q  <= '0;
			ch_q    <= '0;
			sym_q   <= '0;
			grp_q   <= '0;
			acci_q  <= '0;
			accq_q  <= '0;
			ob_q    <= '0;
			olane_q <= '0;
			ov_q    <= 1'b0;
			od_q    <= '0;
			ol_q    <= 1'b0;
		end else begin
			state_q <= state_d;
			mode_q  <= mode_d;
			ant_q   <= ant_d;
			bits_q  <= bits_d;
			red_q   <= red_d;
			cplx_q  <= cplx_d;
			nch_q   <= nch_d;
			ratio_q <= ratio_d;
			len_q   <= len_d;
			samp_q  <= samp_d;
			wcnt_q  <= wcnt_d;
			cand_q  <= cand_d;
			aidx_q  <= aidx_d;
			acc0_q  <= acc0_d;
			acc1_q  <= acc1_d;
			bc_q    <= bc_d;
			bi_q    <= bi_d;
			sum_q   <= sum_d;
			word_q  <= word_d;
			have_q  <= have_d;
			lane_q  <= lane_d;
			ch_q    <= ch_d;
			sym_q   <= sym_d;
			grp_q   <= grp_d;
			acci_q  <= acci_d;
			accq_q  <= accq_d;
			ob_q    <= ob_d;
			olane_q <= olane_d;
			ov_q    <= ov_d;
			od_q    <= od_d;
			ol_q    <= ol_d;
		end
	end
endmodule

//--- rtl/codec_host.sv
// Sending end: cleans user words, holds packet settings, returns results
`timescale 1ns/1ps
module codec_host
	import codec_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire logic              usr_valid,
	output logic                   usr_ready,
	input  wire logic [WORD_W-1:0] usr_data,
	input  wire logic              usr_last,
	input  wire mode_type          mode,
	input  wire logic [ANT_W-1:0]  ant_count,
	input  wire logic [INFO_W-1:0] info_bits,
	input  wire logic              reduced,
	input  wire logic              cplx,
	input  wire logic              ext_cp,
	input  wire logic [CHAN_W-1:0] num_chan,
	input  wire ratio_arr_type     spread_ratio,
	input  wire len_arr_type       chan_len,
	output logic                   rsp_valid,
	input  wire logic              rsp_ready,
	output logic [WORD_W-1:0]      rsp_data,
	output logic                   rsp_last,
	codec_link_if.host             link
);
	logic              first_q, first_d, par_q, par_d, ext_q, ext_d;
	mode_type          mode_q, mode_d;
	logic [ANT_W-1:0]  ant_q, ant_d;
	logic [INFO_W-1:0] bits_q, bits_d;
	logic              red_q, red_d, cplx_q, cplx_d;
	logic [CHAN_W-1:0] nch_q, nch_d, ch_q, ch_d;
	ratio_arr_type     ratio_q, ratio_d;
	len_arr_type       len_q, len_d;
	logic [LEN_W-1:0]  cnt_q, cnt_d, rem, cap;
	logic              lv_q, lv_d, ll_q, ll_d, rv_q, rv_d, rl_q, rl_d;
	logic [WORD_W-1:0] ld_q, ld_d, rd_q, rd_d, clean;
	logic [CHAN_W-1:0] ch_cur;
	logic [LEN_W-1:0]  cnt_cur;
	logic              par_cur;

	// ****************************************
	// Word cleaning and link drive
	// ****************************************
	always_comb begin
		first_d = first_q;
		par_d   = par_q;
		ext_d   = ext_q;
		mode_d  = mode_q;
		ant_d   = ant_q;
		bits_d  = bits_q;
		red_d   = red_q;
		cplx_d  = cplx_q;
		nch_d   = nch_q;
		ratio_d = ratio_q;
		len_d   = len_q;
		ch_d    = ch_q;
		cnt_d   = cnt_q;
		lv_d    = lv_q && !link.in_ready;
		ld_d    = ld_q;
		ll_d    = ll_q;
		usr_ready = !lv_q || link.in_ready;
		// The first word of a packet is cleaned with the settings on the user pins
		if (first_q) begin
			mode_d  = mode;
			ant_d   = ant_count;
			bits_d  = info_bits;
			red_d   = reduced;
			cplx_d  = cplx;
			nch_d   = num_chan;
			ratio_d = spread_ratio;
			len_d   = chan_len;
			ext_d   = ext_cp;
		end
		ch_cur  = first_q ? '0 : ch_q;
		cnt_cur = first_q ? '0 : cnt_q;
		par_cur = first_q ? 1'b0 : par_q;
		rem     = len_d[ch_cur] - cnt_cur;
		cap     = cplx_d ? LEN_W'(CPLX_LANES) : LEN_W'(LANES);
		clean   = usr_data;
		if (mode_d == MODE_CORR) begin
			if (par_cur) begin
				clean[RES_LANE*LANE_W +: 2*LANE_W] = '0;
			end
			if (ext_d && par_cur) begin
				clean[EXT_CP_LANE_A*LANE_W +: LANE_W] = '0;
				clean[EXT_CP_LANE_B*LANE_W +: LANE_W] = '0;
			end
		end else begin
			// Pad lanes past the channel length go out as zero
			for (int l = 0; l < LANES; l++) begin
				if (LEN_W'(cplx_d ? l / 2 : l) >= rem) begin
					clean[l*LANE_W +: LANE_W] = '0;
				end
			end
		end
		// Words pass whole; each hypothesis or antenna set is its own packet
		if (usr_valid && usr_ready) begin
			lv_d    = 1'b1;
			ld_d    = clean;
			ll_d    = usr_last;
			first_d = usr_last;
			par_d   = !par_cur;
			ch_d    = ch_cur;
			cnt_d   = cnt_cur + cap;
			// A channel ending in this word makes the next word open the next channel
			if (rem <= cap) begin
				ch_d  = ch_cur + CHAN_W'(1);
				cnt_d = '0;
			end
		end
		rv_d = rv_q && !rsp_ready;
		rd_d = rd_q;
		rl_d = rl_q;
		link.out_ready = !rv_q || rsp_ready;
		if (link.out_valid && link.out_ready) begin
			rv_d = 1'b1;
			rd_d = link.out_data;
			rl_d = link.out_last;
		end
	end

	// Settings stay steady from the first user word until the last one is taken from the user, not until the device takes it
	assign link.in_valid     = lv_q;
	assign link.in_data      = ld_q;
	assign link.in_last      = ll_q;
	assign link.mode         = mode_q;
	assign link.ant_count    = ant_q;
	assign link.info_bits    = bits_q;
	assign link.reduced      = red_q;
	assign link.cplx         = cplx_q;
	assign link.num_chan     = nch_q;
	assign link.spread_ratio = ratio_q;
	assign link.chan_len     = len_q;
	assign rsp_valid         = rv_q;
	assign rsp_data          = rd_q;
	assign rsp_last          = rl_q;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			first_q <= 1'b1;
			par_q   <= 1'b0;
			ext_q   <= 1'b0;
			mode_q  <= MODE_CORR;
			ant_q   <= '0;
			bits_q  <= '0;
			red_q   <= 1'b0;
			cplx_q  <= 1'b0;
			nch_q   <= '0;
			ratio_q <= '0;
			len_q   <= '0;
			ch_q    <= '0;
			cnt_q   <= '0;
			lv_q    <= 1'b0;
			ld_q    <= '0;
			ll_q    <= 1'b0;
			rv_q    <= 1'b0;
			rd_q    <= '0;
			rl_q    <= 1'b0;
		end else begin
			first_q <= first_d;
			par_q   <= par_d;
			ext_q   <= ext_d;
			mode_q  <= mode_d;
			ant_q   <= ant_d;
			bits_q  <= bits_d;
			red_q   <= red_d;
			cplx_q  <= cplx_d;
			nch_q   <= nch_d;
			ratio_q <= ratio_d;
			len_q   <= len_d;
			ch_q    <= ch_d;
			cnt_q   <= cnt_d;
			lv_q    <= lv_d;
			ld_q    <= ld_d;
			ll_q    <= ll_d;
			rv_q    <= rv_d;
			rd_q    <= rd_d;
			rl_q    <= rl_d;
		end
	end
endmodule

//--- tb/codec_link_props.sv
// Concurrent checks on the correlator / despreader packet link
`timescale 1ns/1ps
module codec_link_props
	import codec_pkg::*;
(
	input wire logic              sys_clk,
	input wire logic              rst,
	input wire logic              in_ready,
	input wire mode_type          mode,
	input wire logic [INFO_W-1:0] info_bits,
	input wire logic              out_valid,
	input wire logic              out_ready,
	input wire logic [WORD_W-1:0] out_data,
	input wire logic              out_last
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	logic w0;
	logic w1;
	assign w0 = out_valid && !out_last && mode == MODE_CORR;
	assign w1 = out_valid && out_last && mode == MODE_CORR;
	out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
		else $error("output word changed before taken");
	corr_refuse_a: assert property (out_valid && mode == MODE_CORR |-> !in_ready)
		else $error("input taken during result");
	idx_pad_a: assert property (w0 |-> {out_data[63:61], out_data[47:45],
		out_data[31:29], out_data[15:13]} == 12'h0) else $error("index lane upper bits set");
	idx_range_a: assert property (w0 |-> (out_data[12:0] >> info_bits) == 0)
		else $error("index wider than sequence");
	corr_pad_a: assert property (w0 |-> out_data[95:89] == 0 && out_data[127:121] == 0)
		else $error("best value upper bits set");
	rank_top_a: assert property (w0 |-> out_data[88:64] >= out_data[120:96])
		else $error("best two out of order");
	rank_low_a: assert property (w1 |-> out_data[24:0] >= out_data[56:32])
		else $error("last two out of order");
	tail_zero_a: assert property (w1 |-> out_data[127:96] == 0 && out_data[31:25] == 0)
		else $error("reserved output bits set");
	pair_order_a: assert property (w0 && out_ready |=> !w0)
		else $error("second result word missing");
	cover property (w1 && out_ready);
	cover property (out_valid && out_last && mode == MODE_DESPREAD);
	cover property (out_valid && !out_ready);
endmodule

//--- tb/tb_top.sv
// Link bench: random correlation and despread packets
`timescale 1ns/1ps
module tb_top;
	import codec_pkg::*;
	logic              sys_clk, rst, usr_valid, usr_ready, usr_last, reduced, cplx, ext_cp;
	logic              rsp_valid, rsp_last, busy;
	logic              rsp_ready = 1'b1;
	logic [WORD_W-1:0] usr_data, rsp_data;
	logic [ANT_W-1:0]  ant_count;
	logic [INFO_W-1:0] info_bits;
	logic [CHAN_W-1:0] num_chan;
	mode_type          mode;
	ratio_arr_type     spread_ratio;
	len_arr_type       chan_len;
	logic [WORD_W:0]   got[$], exp[$];
	int                fail_count, comparisons;
	codec_link_if link_if();
	codec_host codec_host_inst(.sys_clk, .rst, .usr_valid, .usr_ready, .usr_data, .usr_last,
		.mode, .ant_count, .info_bits, .reduced, .cplx, .ext_cp, .num_chan, .spread_ratio,
		.chan_len, .rsp_valid, .rsp_ready, .rsp_data, .rsp_last, .link(link_if));
	codec_device codec_device_inst(.sys_clk, .rst, .busy, .link(link_if));
	codec_link_props codec_link_props_inst(.sys_clk, .rst, .in_ready(link_if.in_ready),
		.mode(link_if.mode), .info_bits(link_if.info_bits), .out_valid(link_if.out_valid),
		.out_ready(link_if.out_ready), .out_data(link_if.out_data), .out_last(link_if.out_last));
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	// Result side stalls at random to exercise held output words
	always @(posedge sys_clk) begin
		if (rsp_valid && rsp_ready)
			got.push_back({rsp_last, rsp_data});
		rsp_ready <= rst || ($urandom_range(0, 3) != 0);
	end
	task automatic tally_and_finish;
		if (fail_count == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic send(input logic [WORD_W-1:0] w, input logic l);
		int i;
		usr_valid <= 1'b1;
		usr_data <= w;
		usr_last <= l;
		// Ready is combinational; look at it only once it has settled after the edge
		@(negedge sys_clk);
		for (i = 0; i < 4000 && usr_ready !== 1'b1; i++)
			@(negedge sys_clk);
		if (i == 4000) begin
			fail_count++;
			tally_and_finish();
		end
		@(posedge sys_clk);
	endtask
	task automatic check_words;
		logic [WORD_W:0] a, e;
		for (int i = 0; i < 4000 && got.size() < exp.size(); i++)
			@(posedge sys_clk);
		if (got.size() < exp.size()) begin
			fail_count++;
			tally_and_finish();
		end
		while (exp.size() > 0) begin
			a = got.pop_front();
			e = exp.pop_front();
			comparisons++;
			if (a !== e) begin
				fail_count++;
				$display("mismatch t=%0t exp=%h act=%h", $time, e, a);
			end
		end
		// Every result is out, so the device must be back at rest
		comparisons++;
		if (busy !== 1'b0) begin
			fail_count++;
			$display("mismatch t=%0t exp=%h act=%h", $time, 1'b0, busy);
		end
	endtask
	task automatic corr_case(input int d, input int p, input logic r);
		int n, q, c0, c1;
		logic [15:0] y, pl;
		n = $urandom_range(1, 2);
		q = $urandom_range(0, 1);
		ext_cp <= q[0];
		q = (q[0] ? 2 : 4) * p;
		y = {8'h00, 8'(d)};
		pl = {8'h00, 8'(p)};
		c0 = n * ((10 * d + q) ** 2 + 100 * d * d);
		c1 = n * ((q - 10 * d) ** 2 + 100 * d * d);
		mode <= MODE_CORR;
		reduced <= r;
		info_bits <= r ? 4'h6 : 4'h1;
		ant_count <= 4'(n);
		for (int k = 0; k < n; k++) begin
			send({8{y}}, 1'b0);
			send({{4{pl}}, 32'h5a5a_a5a5, {2{y}}}, k == n - 1);
		end
		usr_valid <= 1'b0;
		// Reduced search with silent data: all results tie, so insertion order ranks them
		if (r)
			exp.push_back({1'b0, 7'h0, 25'(c0), 7'h0, 25'(c0), 64'h0022_0002_0020_0000});
		else if (c1 > c0)
			exp.push_back({1'b0, 7'h0, 25'(c0), 7'h0, 25'(c1), 48'h0, 16'h1});
		else
			exp.push_back({1'b0, 7'h0, 25'(c1), 7'h0, 25'(c0), 32'h0, 16'h1, 16'h0});
		exp.push_back(r ? {1'b1, 32'h0, 32'(c0), 7'h0, 25'(c0), 7'h0, 25'(c0)}
			: {1'b1, 32'h0, 32'((c0 + c1) >> 1), 64'h0});
		check_words();
	endtask
	task automatic desp_case(input logic cx);
		int lw, t, ai, aq, k, i, rt[2], ln[2];
		logic [31:0] s;
		logic [WORD_W+15:0] w, o;
		lw = cx ? 4 : 8;
		for (i = 0; i < 2; i++) begin
			rt[i] = $urandom_range(1, 4);
			ln[i] = $urandom_range(rt[i], 13);
			spread_ratio[i] <= 8'(rt[i]);
			chan_len[i] <= 16'(ln[i]);
		end
		mode <= MODE_DESPREAD;
		cplx <= cx;
		for (int c = 0; c < 2; c++) begin
			{ai, aq, k} = 96'h0;
			o = '0;
			t = (ln[c] + lw - 1) / lw * lw;
			for (i = 0; i < t; i++) begin
				s = {16'($urandom_range(0, 1023) - 512), 16'($urandom_range(0, 1023) - 512)};
				w[i % lw * (128 / lw) +: 32] = s;
				ai += i < ln[c] ? $signed(s[15:0]) : 0;
				aq += i < ln[c] && cx ? $signed(s[31:16]) : 0;
				if (i < ln[c] && i % rt[c] == rt[c] - 1) begin
					o[k % lw * (128 / lw) +: 32] = {aq[15:0], ai[15:0]};
					{ai, aq} = 64'h0;
					k++;
					if (k % lw == 0) begin
						exp.push_back({1'b0, o[WORD_W-1:0]});
						o = '0;
					end
				end
				if (i % lw == lw - 1)
					send(w[WORD_W-1:0], c == 1 && i == t - 1);
			end
			if (k % lw != 0)
				exp.push_back({1'b0, o[WORD_W-1:0]});
		end
		usr_valid <= 1'b0;
		exp[exp.size() - 1][WORD_W] = 1'b1;
		check_words();
	endtask
	initial begin
		{usr_valid, usr_last, reduced, cplx, ext_cp} = 5'h0;
		usr_data = '0;
		mode = MODE_CORR;
		ant_count = 4'h1;
		info_bits = 4'h1;
		num_chan = 3'h2;
		spread_ratio = {MAX_CHAN{8'h01}};
		chan_len = {MAX_CHAN{16'h0001}};
		rst = 1'b1;
		void'($urandom(32'h7f26));
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		corr_case(-60, 60, 1'b0);
		corr_case(0, 1, 1'b0);
		repeat (6) corr_case($urandom_range(0, 120) - 60, $urandom_range(1, 60), 1'b0);
		repeat (2) corr_case(0, 7, 1'b1);
		repeat (4) desp_case(1'b0);
		repeat (4) desp_case(1'b1);
		tally_and_finish();
	end
endmodule
